/* File: hdl/ldac_defs.svh */
// Purpose: offsets, field positions, reset values for the ladder converter control
// Assumes: AHB-Lite word-aligned registers, 8-bit data in the low byte
// Notes: offsets are local choices
`ifndef LDAC_DEFS_SVH
`define LDAC_DEFS_SVH

`define LDAC_OFS_CTRL 4'h0
`define LDAC_OFS_LEVEL 4'h4
`define LDAC_BIT_ENABLE 7
`define LDAC_BIT_OE1 5
`define LDAC_BIT_OE2 4
`define LDAC_PSS_HI 3
`define LDAC_PSS_LO 2
`define LDAC_LEVEL_HI 4
`define LDAC_CTRL_RESET 8'h00
`define LDAC_LEVEL_RESET 5'h00
`define LDAC_CTRL_WMASK 8'hBC
`define LDAC_TAPS 32

`endif

/* File: hdl/ldac_pkg.sv */
// Purpose: shared types of the ladder converter control
// Assumes: nothing
// Notes: types only
`default_nettype none
package ldac_pkg;
  typedef enum logic [1:0] {
    LDAC_PSEL_SUPPLY,
    LDAC_PSEL_EXTPIN,
    LDAC_PSEL_FIXED,
    LDAC_PSEL_RESERVED
  } ldac_psel_t;

  typedef struct packed {
    logic converter_enable;
    logic output_pin1_enable;
    logic output_pin2_enable;
    logic [1:0] positive_ref_select;
    logic [4:0] level_code;
  } ldac_cfg_t;
endpackage
`default_nettype wire

/* File: hdl/ldac_tap_decode.sv */
// Purpose: one-hot ladder tap select from the level code
// Assumes: tap k joins the output to k/32 of the ladder span above the low end
// Notes: all taps off while the converter is disabled
`include "ldac_defs.svh"
`default_nettype none
module ldac_tap_decode (
  input wire logic enable,
  input wire logic [4:0] level_code,
  output logic [`LDAC_TAPS-1:0] tap_select
);
  genvar i;
  generate
    for (i = 0; i < `LDAC_TAPS; i = i + 1) begin : g_tap
      // Output = low + (high - low) * code / 32
      assign tap_select[i] = enable && (level_code == 5'(i));
    end
  endgenerate
endmodule
`default_nettype wire

/* File: hdl/ldac_pin_ctrl.sv */
// Purpose: pin overrides for one analog output pin
// Assumes: pad logic obeys the override lines
// Notes: one instance per output pin
`default_nettype none
module ldac_pin_ctrl (
  input wire logic route_enable,
  input wire logic pad_in,
  output logic analog_connect,
  output logic digital_override,
  output logic pullup_disable,
  output logic current_drive_disable,
  output logic pad_read
);
  always_comb begin
    analog_connect = route_enable;
    digital_override = route_enable;
    pullup_disable = route_enable;
    current_drive_disable = route_enable;
    pad_read = route_enable ? 1'b0 : pad_in;
  end
endmodule
`default_nettype wire

/* File: hdl/ldac_control.sv */
// Purpose: register file and analog control outputs of a 5-bit ladder converter
// Assumes: AHB-Lite slave, zero wait states, OKAY only, word accesses
// Notes: no sleep input; state simply holds while the clock keeps running
`include "ldac_defs.svh"
`default_nettype none
module ldac_control (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pin1_pad_in,
  input wire logic pin2_pad_in,
  output logic converter_active,
  output logic [`LDAC_TAPS-1:0] tap_select,
  output logic ref_sel_supply,
  output logic ref_sel_extpin,
  output logic ref_sel_fixed,
  output logic ref_sel_negative_supply,
  output logic analog_out_pin1,
  output logic analog_out_pin2,
  output logic pin1_digital_override,
  output logic pin2_digital_override,
  output logic pin1_pullup_disable,
  output logic pin2_pullup_disable,
  output logic pin1_drive_disable,
  output logic pin2_drive_disable,
  output logic pin1_read,
  output logic pin2_read
);
  typedef struct packed {
    ldac_pkg::ldac_cfg_t cfg;
    logic wr_pend;
    logic [3:0] wr_addr;
    logic [31:0] rdata;
  } ldac_state_t;

  ldac_state_t state_reg;
  ldac_state_t state_next;
  logic addr_phase;
  logic [7:0] ctrl_view;
  logic [7:0] level_view;
  logic [7:0] wbyte;

  assign addr_phase = hsel && hready && htrans[1];
  assign wbyte = hwdata[7:0];

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[`LDAC_BIT_ENABLE] = state_reg.cfg.converter_enable;
    ctrl_view[`LDAC_BIT_OE1] = state_reg.cfg.output_pin1_enable;
    ctrl_view[`LDAC_BIT_OE2] = state_reg.cfg.output_pin2_enable;
    ctrl_view[`LDAC_PSS_HI:`LDAC_PSS_LO] = state_reg.cfg.positive_ref_select;
    // Bit 0 negative select is fixed to the ground side
    level_view = {3'h0, state_reg.cfg.level_code};
  end

  always_comb begin
    state_next = state_reg;
    state_next.wr_pend = 1'b0;
    if (state_reg.wr_pend) begin
      // Direct update, no shadow stage
      if (state_reg.wr_addr == `LDAC_OFS_CTRL) begin
        state_next.cfg.converter_enable = wbyte[`LDAC_BIT_ENABLE];
        state_next.cfg.output_pin1_enable = wbyte[`LDAC_BIT_OE1];
        state_next.cfg.output_pin2_enable = wbyte[`LDAC_BIT_OE2];
        state_next.cfg.positive_ref_select = wbyte[`LDAC_PSS_HI:`LDAC_PSS_LO];
      end else if (state_reg.wr_addr == `LDAC_OFS_LEVEL) begin
        state_next.cfg.level_code = wbyte[`LDAC_LEVEL_HI:0];
      end
    end
    if (addr_phase) begin
      state_next.wr_pend = hwrite;
      state_next.wr_addr = haddr[3:0];
      if (!hwrite) begin
        case (haddr[3:0])
          `LDAC_OFS_CTRL: state_next.rdata = {24'h000000, ctrl_view};
          `LDAC_OFS_LEVEL: state_next.rdata = {24'h000000, level_view};
          default: state_next.rdata = 32'h00000000;
        endcase
      end
    end
    if (!reset_n) begin
      // All control bits cleared; reset wins over a write pending in the same cycle
      state_next.cfg = '0;
      state_next.wr_pend = 1'b0;
      state_next.wr_addr = 4'h0;
      state_next.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge clock) begin
    state_reg <= state_next;
  end

  assign hrdata = state_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Converter runs only with its enable set
  assign converter_active = state_reg.cfg.converter_enable;

  always_comb begin
    ref_sel_supply = 1'b0;
    ref_sel_extpin = 1'b0;
    ref_sel_fixed = 1'b0;
    // Reserved code connects no positive reference, so the ladder top floats rather than shorts
    case (ldac_pkg::ldac_psel_t'(state_reg.cfg.positive_ref_select))
      ldac_pkg::LDAC_PSEL_SUPPLY: ref_sel_supply = converter_active;
      ldac_pkg::LDAC_PSEL_EXTPIN: ref_sel_extpin = converter_active;
      ldac_pkg::LDAC_PSEL_FIXED: ref_sel_fixed = converter_active;
      default: ref_sel_supply = 1'b0;
    endcase
    ref_sel_negative_supply = converter_active;
  end

  ldac_tap_decode u_taps (
    .enable(converter_active),
    .level_code(state_reg.cfg.level_code),
    .tap_select(tap_select)
  );

  ldac_pin_ctrl u_pin1 (
    .route_enable(state_reg.cfg.output_pin1_enable),
    .pad_in(pin1_pad_in),
    .analog_connect(analog_out_pin1),
    .digital_override(pin1_digital_override),
    .pullup_disable(pin1_pullup_disable),
    .current_drive_disable(pin1_drive_disable),
    .pad_read(pin1_read)
  );

  ldac_pin_ctrl u_pin2 (
    .route_enable(state_reg.cfg.output_pin2_enable),
    .pad_in(pin2_pad_in),
    .analog_connect(analog_out_pin2),
    .digital_override(pin2_digital_override),
    .pullup_disable(pin2_pullup_disable),
    .current_drive_disable(pin2_drive_disable),
    .pad_read(pin2_read)
  );
endmodule
`default_nettype wire

/* File: testbench/ldac_control_props.sv */
// Purpose: port-level checks of the ladder converter control
// Assumes: zero-wait bus slave, hready tied to hreadyout
// Notes: pin2 overrides are checked by a_pin2 in the same way as pin1
`default_nettype none
module ldac_control_props (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic pin1_pad_in,
  input wire logic pin2_pad_in,
  input wire logic converter_active,
  input wire logic [31:0] tap_select,
  input wire logic ref_sel_supply,
  input wire logic ref_sel_extpin,
  input wire logic ref_sel_fixed,
  input wire logic ref_sel_negative_supply,
  input wire logic analog_out_pin1,
  input wire logic analog_out_pin2,
  input wire logic pin1_digital_override,
  input wire logic pin1_pullup_disable,
  input wire logic pin1_drive_disable,
  input wire logic pin1_read,
  input wire logic pin2_digital_override,
  input wire logic pin2_pullup_disable,
  input wire logic pin2_drive_disable,
  input wire logic pin2_read
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic tk;
  logic [2:0] rs;
  assign tk = hsel && hready && htrans[1];
  assign rs = {ref_sel_supply, ref_sel_extpin, ref_sel_fixed};
  property p_off; !converter_active |-> tap_select == 32'h0 && rs == 3'h0; endproperty
  a_off: assert property (p_off) else $error("controls live while disabled");
  property p_tap; converter_active |-> $onehot(tap_select); endproperty
  a_tap: assert property (p_tap) else $error("tap select not one-hot");
  property p_ref; $onehot0(rs) && ref_sel_negative_supply == converter_active; endproperty
  a_ref: assert property (p_ref) else $error("reference select malformed");
  property p_ovr; {3{analog_out_pin1}} ==
    {pin1_digital_override, pin1_pullup_disable, pin1_drive_disable}; endproperty
  a_ovr: assert property (p_ovr) else $error("pin overrides differ from route");
  property p_rd; pin1_read == (!analog_out_pin1 && pin1_pad_in); endproperty
  a_rd: assert property (p_rd) else $error("routed pin read not zero");
  property p_pin2; {3{analog_out_pin2}} ==
    {pin2_digital_override, pin2_pullup_disable, pin2_drive_disable}
    && pin2_read == (!analog_out_pin2 && pin2_pad_in); endproperty
  a_pin2: assert property (p_pin2) else $error("pin2 overrides wrong");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not ready and okay");
  property p_wr; tk && hwrite && haddr[3:0] == 4'h0 ##1 1'b1 |=> converter_active ==
    $past(hwdata[7]) && {analog_out_pin1, analog_out_pin2} == $past(hwdata[5:4]); endproperty
  a_wr: assert property (p_wr) else $error("control write not applied");
  property p_rsv; tk && !hwrite |=>
    (hrdata & ($past(haddr[2]) ? 32'hFFFFFFE0 : 32'hFFFFFF43)) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_rst; disable iff (1'b0) !reset_n |=> !converter_active && !analog_out_pin1
    && !analog_out_pin2 && tap_select == 32'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset left controls active");
  c_en: cover property (converter_active && analog_out_pin1);
  c_fix: cover property (ref_sel_fixed);
  c_top: cover property (tap_select[31]);
endmodule
bind ldac_control ldac_control_props ldac_control_props_i (.*);
`default_nettype wire

/* File: testbench/tb.sv */
// Purpose: self-checking bench for the ladder converter control
// Assumes: zero-wait bus slave, pads held high until the last check
// Notes: outputs other than hrdata are sampled at the falling edge to avoid edge races
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, reset_n, hsel, hwrite, pin1_pad_in, pin2_pad_in, hready, hreadyout, hresp;
  logic converter_active, ref_sel_supply, ref_sel_extpin, ref_sel_fixed, ref_sel_negative_supply;
  logic analog_out_pin1, analog_out_pin2, pin1_digital_override, pin2_digital_override;
  logic pin1_pullup_disable, pin2_pullup_disable, pin1_drive_disable, pin2_drive_disable;
  logic pin1_read, pin2_read;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, tap_select;
  logic [9:0] o;
  int failures, checks, cyc;
  int lv[4] = '{0, 1, 17, 31};
  assign hready = hreadyout;
  assign o = {converter_active, analog_out_pin1, analog_out_pin2, pin1_digital_override,
    pin2_pullup_disable, pin1_read, ref_sel_supply, ref_sel_extpin, ref_sel_fixed,
    ref_sel_negative_supply};
  ldac_control ldac_control_i (.*);
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  task test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task ap(input logic [31:0] a, input logic w);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (!hready);
    hsel <= 1'b0;
    htrans <= 2'h0;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    ap(a, 1'b1);
    hwdata <= d;
    do @(posedge clock); while (!hready);
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    ap(a, 1'b0);
    do @(posedge clock); while (!hready);
    chk(hrdata, e);
  endtask
  task co(input logic [9:0] e, input logic [31:0] t);
    @(negedge clock);
    chk({22'h0, o}, {22'h0, e});
    chk(tap_select, t);
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc > 1000) begin
      failures++;
      test_done();
    end
  end
  initial begin
    {reset_n, hsel, hwrite, htrans} <= 5'h0;
    {haddr, hwdata} <= 64'h0;
    {hsize, pin1_pad_in, pin2_pad_in} <= 5'h0B;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    co(10'h010, 32'h0);
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h0);
    wr(32'h0, 32'hFF);
    co(10'h3E1, 32'h1);
    rd(32'h0, 32'hBC);
    for (int k = 0; k < 3; k++) begin
      wr(32'h0, 32'h80 | (k << 2));
      co({6'b100001, 3'b100 >> k, 1'b1}, 32'h1);
    end
    foreach (lv[i]) begin
      wr(32'h4, 32'hE0 | lv[i]);
      co(10'h213, 32'h1 << lv[i]);
    end
    rd(32'h4, 32'h1F);
    wr(32'h0, 32'h0);
    co(10'h010, 32'h0);
    rd(32'h4, 32'h1F);
    wr(32'h8, 32'hFF);
    rd(32'h8, 32'h0);
    rd(32'h0, 32'h0);
    wr(32'h0, 32'hB0);
    co(10'h3E9, 32'h80000000);
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    co(10'h010, 32'h0);
    rd(32'h4, 32'h0);
    // Low pads prove the unrouted read follows the pad, not a constant
    {pin1_pad_in, pin2_pad_in} <= 2'b00;
    co(10'h000, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
